// [smcw_host.sv]
// smcw_host.sv: host model shifting 32-bit frames into the serial port
// assumes: clock_in from the bench, send called by the bench
`timescale 1ns/100ps
module smcw_host (
  input wire logic clock_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_le_out
);
  int hold = 5;
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_le_out = 1'b0;
  end
  // msb first, address last, latch only after all bits
  task automatic send(input logic [31:0] frame, input bit latch);
    for (int i = 31; i >= 0; i--) begin
      ser_data_out = frame[i];
      repeat (hold) @(negedge clock_in);
      ser_clk_out = 1'b1;
      repeat (hold) @(negedge clock_in);
      ser_clk_out = 1'b0;
    end
    ser_data_out = ~frame[0];
    ser_le_out = latch;
    repeat (10) @(negedge clock_in);
    ser_le_out = 1'b0;
    repeat (hold) @(negedge clock_in);
  endtask
endmodule // smcw_host

// [smcw_map.vh]
// smcw_map.vh: bit positions, codes and reset values of the synthesizer miscellaneous control word
// assumes: included by the design files of the smcw block
`ifndef SMCW_MAP_VH
`define SMCW_MAP_VH
`define SMCW_ADDR_BITS 4
`define SMCW_DATA_BITS 28
`define SMCW_ADDR_MISC 4'h3
`define SMCW_ADDR_CAP4 4'h4
`define SMCW_CAP4_LSB 14
`define SMCW_MODE_LSB 0
`define SMCW_PDN_BIT 2
`define SMCW_XO_BIT 3
`define SMCW_CPG_LSB 4
`define SMCW_MUX_LSB 9
`define SMCW_CPP_BIT 13
`define SMCW_DBL_BIT 14
`define SMCW_FDM_BIT 15
`define SMCW_ORDER_LSB 16
`define SMCW_MISC_RESET 28'h0008000
`define SMCW_CAP4_RESET 4'h0
`define SMCW_MODE_FULL 2'h0
`define SMCW_MODE_EXTVCO 2'h1
`define SMCW_MODE_DIVONLY 2'h2
`define SMCW_LOCK_COUNT 3'h5
`define SMCW_SHIFT_BITS 32
`endif

// [smcw_misc_control.v]
// smcw_misc_control.v: three-wire serial loaded misc control word and its decode
// assumes: serial pins and lock/divider probes arrive asynchronously; analog blocks take the decoded outputs
// Notes on behaviour
// - filter cap code 0..15 selects 0..165 pF, only in full mode
// - mode 0 all on, 1 oscillator off, 2 divider only, 3 test
// - power-down stops divider, pll, oscillator and lock detect, registers and calibration kept
// - crystal bit turns reference pins into crystal oscillator
// - pump current is (code+1) times 100 uA
// - select 0,1,2 give high impedance, drive high, drive low
// - select 3..7 give the lock indications in their drive styles
// - digital lock select 3 drives pin high when locked, else low
// - select 8..11 give dividers, halved ones 50% duty; 12,13 give detector up, down; 14,15 reserved
// - polarity bit 0 negative, 1 positive
// - doubler bit doubles reference and bypasses reference divider
// - wide denominator bit 0 uses 10 bits, 1 (default) 22 bits
// - order 0 integer, 1..4 fractional order, 5..7 illegal
// - first order has no dithering nor analog compensation
// - integer mode allows larger feedback counter range
// - lock after 5 good detector cycles, held until window exceeded
`timescale 1ns/100ps
`include "smcw_map.vh"
module smcw_misc_control (
  input wire clock_in,
  input wire sys_rst_in,
  input wire ser_clk_in,
  input wire ser_data_in,
  input wire ser_le_in,
  input wire pd_cycle_in,
  input wire pd_in_window_in,
  input wire analog_lock_in,
  input wire fb_div_in,
  input wire ref_div_in,
  input wire pd_up_in,
  input wire pd_down_in,
  output reg [3:0] filter_cap_four_code_out,
  output reg [7:0] filter_cap_pf_out,
  output reg divider_en_out,
  output reg pll_en_out,
  output reg osc_en_out,
  output reg test_mode_out,
  output reg power_down_out,
  output reg crystal_mode_bit_out,
  output reg [4:0] pump_current_code_out,
  output reg [11:0] pump_current_ua_out,
  output reg pump_polarity_bit_out,
  output reg ref_doubler_bit_out,
  output reg ref_div_bypass_out,
  output reg wide_denominator_bit_out,
  output reg [4:0] frac_width_out,
  output reg [2:0] modulator_order_out,
  output reg modulator_en_out,
  output reg order_illegal_out,
  output reg dither_allowed_out,
  output reg analog_comp_en_out,
  output reg wide_counter_range_out,
  output reg digital_lock_out,
  output wire test_lock_pin_o_out,
  output wire test_lock_pin_oe_out,
  output reg [27:0] misc_control_word_out
);
  wire sclk;
  wire sdat;
  wire sle;
  wire pdc;
  wire pdw;
  wire alock;
  wire fbd;
  wire rfd;
  wire pup;
  wire pdn;
  smcw_sync u_s0 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(ser_clk_in), .sync_out(sclk));
  smcw_sync u_s1 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(ser_data_in), .sync_out(sdat));
  smcw_sync u_s2 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(ser_le_in), .sync_out(sle));
  smcw_sync u_s3 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(pd_cycle_in), .sync_out(pdc));
  smcw_sync u_s4 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(pd_in_window_in), .sync_out(pdw));
  smcw_sync u_s5 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(analog_lock_in), .sync_out(alock));
  smcw_sync u_s6 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(fb_div_in), .sync_out(fbd));
  smcw_sync u_s7 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(ref_div_in), .sync_out(rfd));
  smcw_sync u_s8 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(pd_up_in), .sync_out(pup));
  smcw_sync u_s9 (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .async_in(pd_down_in), .sync_out(pdn));

  // serial shifter: msb first, data 28 bits then 4 address bits
  reg [`SMCW_SHIFT_BITS-1:0] shift;
  reg sclk_d;
  reg sle_d;
  reg [27:0] word;
  reg [3:0] cap4;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      shift <= 32'h00000000;
      sclk_d <= 1'b0;
      sle_d <= 1'b0;
      word <= `SMCW_MISC_RESET;
      cap4 <= `SMCW_CAP4_RESET;
    end else begin
      sclk_d <= sclk;
      sle_d <= sle;
      if (sclk && !sclk_d) begin
        shift <= {shift[30:0], sdat};
      end
      // whole word taken on latch rising edge only
      if (sle && !sle_d) begin
        if (shift[3:0] == `SMCW_ADDR_MISC) begin
          word <= shift[31:4];
        end else if (shift[3:0] == `SMCW_ADDR_CAP4) begin
          cap4 <= shift[`SMCW_CAP4_LSB+4+3:`SMCW_CAP4_LSB+4];
        end
      end
    end
  end

  wire [1:0] mode = word[`SMCW_MODE_LSB+1:`SMCW_MODE_LSB];
  wire pdwn = word[`SMCW_PDN_BIT];
  wire [4:0] pump_current_code = word[`SMCW_CPG_LSB+4:`SMCW_CPG_LSB];
  wire [3:0] sel = word[`SMCW_MUX_LSB+3:`SMCW_MUX_LSB];
  wire [2:0] order = word[`SMCW_ORDER_LSB+2:`SMCW_ORDER_LSB];
  wire full = (mode == `SMCW_MODE_FULL);

  // lock detect: 5 good cycles to lock, one bad cycle unlocks
  reg [2:0] good_cnt;
  reg pdc_d;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      good_cnt <= 3'h0;
      pdc_d <= 1'b0;
      digital_lock_out <= 1'b0;
    end else begin
      pdc_d <= pdc;
      if (pdwn) begin
        good_cnt <= 3'h0;
        digital_lock_out <= 1'b0;
      end else if (pdc && !pdc_d) begin
        if (!pdw) begin
          good_cnt <= 3'h0;
          digital_lock_out <= 1'b0;
        end else if (good_cnt == `SMCW_LOCK_COUNT - 3'h1) begin
          digital_lock_out <= 1'b1;
        end else begin
          good_cnt <= good_cnt + 3'h1;
        end
      end
    end
  end

  // halved divider views, toggled on rising edges
  reg fbd_d;
  reg rfd_d;
  reg fb_half;
  reg rf_half;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      fbd_d <= 1'b0;
      rfd_d <= 1'b0;
      fb_half <= 1'b0;
      rf_half <= 1'b0;
    end else begin
      fbd_d <= fbd;
      rfd_d <= rfd;
      if (fbd && !fbd_d) begin
        fb_half <= ~fb_half;
      end
      if (rfd && !rfd_d) begin
        rf_half <= ~rf_half;
      end
    end
  end

  // test pin multiplexer, registered
  reg pin_o;
  reg pin_oe;
  assign test_lock_pin_o_out = pin_o;
  assign test_lock_pin_oe_out = pin_oe;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= 1'b1;
      pin_o <= 1'b0;
      case (sel)
        4'h0: pin_oe <= 1'b0;
        4'h1: pin_o <= 1'b1;
        4'h2: pin_o <= 1'b0;
        4'h3: pin_o <= digital_lock_out;
        4'h4: pin_o <= ~digital_lock_out;
        4'h5: pin_oe <= ~digital_lock_out;
        4'h6: pin_oe <= ~alock;
        4'h7: pin_o <= alock;
        4'h8: pin_o <= fbd;
        4'h9: pin_o <= fb_half;
        4'ha: pin_o <= rfd;
        4'hb: pin_o <= rf_half;
        4'hc: pin_o <= pup;
        4'hd: pin_o <= pdn;
        default: pin_oe <= 1'b0;
      endcase
    end
  end

  // decoded configuration, registered from the latched word
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      filter_cap_four_code_out <= 4'h0;
      filter_cap_pf_out <= 8'h00;
      divider_en_out <= 1'b0;
      pll_en_out <= 1'b0;
      osc_en_out <= 1'b0;
      test_mode_out <= 1'b0;
      power_down_out <= 1'b0;
      crystal_mode_bit_out <= 1'b0;
      pump_current_code_out <= 5'h00;
      pump_current_ua_out <= 12'h000;
      pump_polarity_bit_out <= 1'b0;
      ref_doubler_bit_out <= 1'b0;
      ref_div_bypass_out <= 1'b0;
      wide_denominator_bit_out <= 1'b1;
      frac_width_out <= 5'h16;
      modulator_order_out <= 3'h0;
      modulator_en_out <= 1'b0;
      order_illegal_out <= 1'b0;
      dither_allowed_out <= 1'b0;
      analog_comp_en_out <= 1'b0;
      wide_counter_range_out <= 1'b0;
      misc_control_word_out <= `SMCW_MISC_RESET;
    end else begin
      misc_control_word_out <= word;
      filter_cap_four_code_out <= cap4;
      // 0,5,20,25,40,45,60,65,100..165: bit0*5 + bit1*20 + bit2*40 + bit3*100
      filter_cap_pf_out <= full ? ({7'h00, cap4[0]} * 8'h05 + {7'h00, cap4[1]} * 8'h14
        + {7'h00, cap4[2]} * 8'h28 + {7'h00, cap4[3]} * 8'h64) : 8'h00;
      divider_en_out <= !pdwn;
      pll_en_out <= !pdwn && (mode != `SMCW_MODE_DIVONLY);
      osc_en_out <= !pdwn && (mode != `SMCW_MODE_DIVONLY) && (mode != `SMCW_MODE_EXTVCO);
      test_mode_out <= (mode == 2'h3);
      power_down_out <= pdwn;
      crystal_mode_bit_out <= word[`SMCW_XO_BIT];
      pump_current_code_out <= pump_current_code;
      pump_current_ua_out <= ({7'h00, pump_current_code} + 12'h001) * 12'h064;
      pump_polarity_bit_out <= word[`SMCW_CPP_BIT];
      ref_doubler_bit_out <= word[`SMCW_DBL_BIT];
      ref_div_bypass_out <= word[`SMCW_DBL_BIT];
      wide_denominator_bit_out <= word[`SMCW_FDM_BIT];
      frac_width_out <= word[`SMCW_FDM_BIT] ? 5'h16 : 5'h0a;
      modulator_order_out <= order;
      modulator_en_out <= (order != 3'h0) && (order < 3'h5);
      order_illegal_out <= (order > 3'h4);
      dither_allowed_out <= (order > 3'h1) && (order < 3'h5);
      analog_comp_en_out <= (order > 3'h1) && (order < 3'h5);
      wide_counter_range_out <= (order == 3'h0);
    end
  end
endmodule // smcw_misc_control

// [smcw_misc_control_asserts.sv]
// smcw_misc_control_asserts.sv: port checks of the misc control word decode
// assumes: bound to smcw_misc_control, one clock, sync reset
`timescale 1ns/100ps
module smcw_asserts (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic ser_le_in,
  input wire logic pd_cycle_in,
  input wire logic pd_in_window_in,
  input wire logic [3:0] filter_cap_four_code_out,
  input wire logic [7:0] filter_cap_pf_out,
  input wire logic divider_en_out,
  input wire logic pll_en_out,
  input wire logic osc_en_out,
  input wire logic power_down_out,
  input wire logic [11:0] pump_current_ua_out,
  input wire logic [4:0] frac_width_out,
  input wire logic modulator_en_out,
  input wire logic order_illegal_out,
  input wire logic dither_allowed_out,
  input wire logic analog_comp_en_out,
  input wire logic wide_counter_range_out,
  input wire logic digital_lock_out,
  input wire logic test_lock_pin_o_out,
  input wire logic test_lock_pin_oe_out,
  input wire logic [27:0] misc_control_word_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire [27:0] w = misc_control_word_out;
  wire [3:0] c = filter_cap_four_code_out;
  logic [2:0] good;
  // good detector edges in a row
  always @(posedge clock_in) begin
    if (sys_rst_in || ($rose(pd_cycle_in) && !pd_in_window_in)) good <= 3'h0;
    else if ($rose(pd_cycle_in) && good != 3'h5) good <= good + 3'h1;
  end
  sequence settled;
    !sys_rst_in [*4];
  endsequence
  sequence bad_edge;
    $rose(pd_cycle_in) && !pd_in_window_in;
  endsequence
  a_pump_current: assert property (settled |-> pump_current_ua_out == (w[8:4] + 12'h1) * 12'h064)
    else $error("pump current");
  a_mode_decode: assert property (settled ##0 (!power_down_out) |-> divider_en_out && pll_en_out == (w[1:0] != 2'h2)
    && osc_en_out == (w[1:0] == 2'h0 || w[1:0] == 2'h3))
    else $error("mode decode");
  a_frac_width: assert property (settled |-> frac_width_out == (w[15] ? 5'h16 : 5'h0a))
    else $error("frac width");
  a_cap_decode: assert property (settled |-> filter_cap_pf_out == ((w[1:0] != 2'h0) ? 8'h00
    : 8'h05 * ({c[2:1], 1'b0, c[0]} + (c[3] ? 8'h14 : 8'h00))))
    else $error("cap decode");
  a_order_decode: assert property (settled |-> modulator_en_out == (w[18:16] != 3'h0 && w[18:16] < 3'h5)
    && order_illegal_out == (w[18:16] > 3'h4) && wide_counter_range_out == (w[18:16] == 3'h0))
    else $error("order decode");
  a_first_order: assert property (settled ##0 (w[18:16] == 3'h1) |-> !dither_allowed_out && !analog_comp_en_out)
    else $error("first order");
  a_pin_fixed: assert property (settled ##0 (w[12:9] < 4'h3 && !power_down_out)
    |-> test_lock_pin_oe_out == (w[12:9] != 4'h0) && test_lock_pin_o_out == (w[12:9] == 4'h1))
    else $error("pin fixed");
  a_pin_lock: assert property (settled ##0 (w[12:9] == 4'h3 && !power_down_out)
    |-> test_lock_pin_oe_out && test_lock_pin_o_out == $past(digital_lock_out))
    else $error("pin lock");
  a_lock_rise: assert property ($rose(digital_lock_out) |-> good == 3'h5)
    else $error("lock early");
  a_lock_drop: assert property (bad_edge |-> ##[1:8] !digital_lock_out)
    else $error("lock held");
  a_word_latch: assert property ($changed(misc_control_word_out) |-> ser_le_in)
    else $error("word without latch");
  a_pdn_lock: assert property (power_down_out [*2] |-> !digital_lock_out)
    else $error("lock in power down");
endmodule // smcw_asserts
bind smcw_misc_control smcw_asserts chk (.*);

// [smcw_sync.v]
// smcw_sync.v: three-flop synchroniser, change accepted when stages two and three agree
// assumes: input comes from outside the clock_in domain
`timescale 1ns/100ps
module smcw_sync (
  input wire clock_in,
  input wire sys_rst_in,
  input wire async_in,
  output reg sync_out
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule // smcw_sync

// [test_smcw_misc_control.sv]
// test_smcw_misc_control.sv: self-checking bench of the misc control word
// assumes: host model drives the serial pins
`timescale 1ns/100ps
module test_smcw_misc_control;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pd_cycle_in = 1'b0, pd_in_window_in = 1'b0;
  logic analog_lock_in = 1'b0, fb_div_in = 1'b0, ref_div_in = 1'b0, pd_up_in = 1'b0, pd_down_in = 1'b0;
  wire [7:0] filter_cap_pf_out;
  wire [3:0] filter_cap_four_code_out;
  wire [4:0] pump_current_code_out, frac_width_out;
  wire [11:0] pump_current_ua_out;
  wire [2:0] modulator_order_out;
  wire [27:0] misc_control_word_out;
  wire ser_clk_in, ser_data_in, ser_le_in, divider_en_out, pll_en_out, osc_en_out, test_mode_out;
  wire power_down_out, crystal_mode_bit_out, pump_polarity_bit_out, ref_doubler_bit_out, ref_div_bypass_out;
  wire wide_denominator_bit_out, modulator_en_out, order_illegal_out, dither_allowed_out, analog_comp_en_out;
  wire wide_counter_range_out, digital_lock_out, test_lock_pin_o_out, test_lock_pin_oe_out;
  int mismatches = 0, num_checks = 0, cycles = 0;
  logic freeze_rand = 1'b0;
  logic [27:0] w;
  logic [3:0] c = 4'h0;
  smcw_misc_control dut (.*);
  smcw_host host (.clock_in(clock_in), .ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in), .ser_le_out(ser_le_in));
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clock_in) begin
    cycles++;
    if (cycles % 8 == 0 && !freeze_rand) {analog_lock_in, fb_div_in, ref_div_in, pd_up_in, pd_down_in} = 5'($urandom);
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [1:0] pin_exp(input logic [3:0] m, input logic l);
    case (m)
      4'h0: return 2'h0;
      4'h1: return 2'h3;
      4'h2: return 2'h2;
      4'h3: return {1'b1, l};
      4'h4: return {1'b1, ~l};
      4'h5: return {~l, 1'b0};
      4'h6: return {~l, 1'b0};
      4'h7: return {1'b1, l};
      default: return 2'h0;
    endcase
  endfunction
  task automatic check_word();
    chk("word", misc_control_word_out, w);
    chk("osc", osc_en_out, w[1:0] == 2'h0 || w[1:0] == 2'h3);
    chk("div", divider_en_out, !w[2]);
    chk("test", test_mode_out, w[1:0] == 2'h3);
    chk("pdn", power_down_out, w[2]);
    chk("cpg", pump_current_code_out, w[8:4]);
    chk("dbl", ref_doubler_bit_out, w[14]);
    chk("fdm", wide_denominator_bit_out, w[15]);
    chk("order", {modulator_en_out, modulator_order_out}, {w[18:16] != 3'h0 && w[18:16] < 3'h5, w[18:16]});
    chk("capcode", filter_cap_four_code_out, c);
    chk("pll", pll_en_out, w[1:0] != 2'h2);
    chk("xo", crystal_mode_bit_out, w[3]);
    chk("ua", pump_current_ua_out, (w[8:4] + 1) * 100);
    chk("cpp", pump_polarity_bit_out, w[13]);
    chk("bypass", ref_div_bypass_out, w[14]);
    chk("frac", frac_width_out, w[15] ? 22 : 10);
    chk("illegal", order_illegal_out, w[18:16] > 3'h4);
    chk("range", wide_counter_range_out, w[18:16] == 3'h0);
    chk("cap", filter_cap_pf_out, (w[1:0] != 0) ? 0 : 5 * ({c[2:1], 1'b0, c[0]} + (c[3] ? 20 : 0)));
    if (w[18:16] == 3'h1) chk("dither", {dither_allowed_out, analog_comp_en_out}, 2'h0);
  endtask
  task automatic pulse(input int n, input logic ok);
    repeat (n) begin
      pd_in_window_in = ok;
      repeat (4) @(negedge clock_in);
      pd_cycle_in = 1'b1;
      repeat (4) @(negedge clock_in);
      pd_cycle_in = 1'b0;
    end
    repeat (8) @(negedge clock_in);
  endtask
  initial begin
    void'($urandom(25));
    repeat (4) @(negedge clock_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    w = 28'h0008000;
    check_word();
    chk("oe", test_lock_pin_oe_out, 1'b0);
    for (int i = 0; i < 16; i++) begin
      w = 28'($urandom);
      w[2] = 1'b0;
      w[1:0] = i[1:0];
      w[18:16] = i[2:0];
      w[12:9] = 4'h3;
      if (i < 2) w[8:4] = {5{i[0]}};
      host.hold = i[0] ? 9 : 5;
      if (i[2]) begin
        c = 4'($urandom);
        host.send({10'($urandom), c, 14'($urandom), 4'h4}, 1'b1);
      end
      host.send({w, 4'h3}, 1'b1);
      check_word();
    end
    host.send({28'($urandom), 4'h5}, 1'b1);
    host.send({28'($urandom), 4'h3}, 1'b0);
    check_word();
    pulse(4, 1'b1);
    chk("lock", digital_lock_out, 1'b0);
    pulse(1, 1'b1);
    chk("lock", digital_lock_out, 1'b1);
    for (int m = 0; m < 12; m++) begin
      if (m == 6) pulse(1, 1'b0);
      w[12:9] = 4'(m % 6);
      host.send({w, 4'h3}, 1'b1);
      chk("pin", {test_lock_pin_oe_out, test_lock_pin_o_out}, pin_exp(w[12:9], m < 6));
    end
    freeze_rand = 1'b1;
    for (int k = 0; k < 4; k++) begin
      w[12:9] = k[1] ? {3'h7, k[0]} : {3'h3, k[0]};
      host.send({w, 4'h3}, 1'b1);
      chk("pin", {test_lock_pin_oe_out, test_lock_pin_o_out}, pin_exp(w[12:9], analog_lock_in));
    end
    freeze_rand = 1'b0;
    pulse(5, 1'b1);
    w[2] = 1'b1;
    host.send({w, 4'h3}, 1'b1);
    chk("pdn", {power_down_out, digital_lock_out}, 2'h2);
    w[2] = 1'b0;
    host.send({w, 4'h3}, 1'b1);
    check_word();
    report_and_stop();
  end
endmodule // test_smcw_misc_control
